// >>> cfp_pkg.sv
package cfp_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int OCP_TIME_US = 1000;
   localparam int OTP_TIME_US = 160;
   localparam int OCP_CYCLES = (OCP_TIME_US * (CLK_HZ / 1000000));
   localparam int OTP_CYCLES = (OTP_TIME_US * (CLK_HZ / 1000000)) + 1;
   localparam int RETRY_CYCLES_DEF = 250000;
   localparam int START_CYCLES_DEF = 25000;
   localparam int PROG_CYCLES_DEF = 2500;
   localparam logic [7:0] ADDR_UNLOCK = 8'h61;
   localparam logic [7:0] ADDR_PROGRAM = 8'h60;
   localparam logic [7:0] ADDR_FAULTS = 8'h54;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h70;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h71;
   localparam logic [7:0] ADDR_CTRL_STATUS = 8'h72;
   localparam logic [7:0] UNLOCK_KEY = 8'h61;
   localparam logic [4:0] PROGRAM_CMD = 5'h12;
   localparam logic [7:0] UNLOCK_RESET = 8'h00;
   localparam logic [4:0] CMD_RESET = 5'h00;
   localparam int CMD_LSB = 3;
   localparam int DONE_BIT = 1;
   localparam int IRQ_W = 4;
   localparam int IRQ_OTP = 0;
   localparam int IRQ_OCP = 1;
   localparam int IRQ_SHORT = 2;
   localparam int IRQ_PROG_DONE = 3;

   typedef enum logic [2:0] {
      CFP_OFF = 3'b000,
      CFP_START = 3'b001,
      CFP_RUN = 3'b010,
      CFP_HICCUP = 3'b011,
      CFP_THERMAL = 3'b100
   } cfp_state_t;

   typedef struct packed {
      logic under_volt;
      logic over_current;
      logic short_circuit;
      logic over_temp;
   } cfp_faults_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cfp_bus_t;
endpackage

// >>> cfp_timer.sv
`timescale 1ns/1ns
module cfp_timer import cfp_pkg::*; #(
   parameter int W = 24
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [W-1:0] limit,
   output logic hit
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic hit;
   } cfp_tmr_t;
   cfp_tmr_t q;
   cfp_tmr_t next_q;

   // Counts while run holds; hit is a level once limit cycles passed
   always_comb begin
      next_q = q;
      if (!run) begin
         next_q.cnt = '0;
         next_q.hit = 1'b0;
      end else if (q.cnt != limit) begin
         next_q.cnt = q.cnt + 1'b1;
         next_q.hit = ((q.cnt + 1'b1) == limit);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign hit = q.hit;
endmodule

// >>> cfp_fault_ctrl.sv
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - Input undervoltage resets all protection and control logic at once.
// - Over-current held 1ms disables output, drops power-good, enters hiccup.
// - Hiccup re-runs startup sequence at intervals while the fault persists.
// - Cleared fault ends hiccup; regulation resumes and power-good may return.
// - Short disables output immediately, hiccups until short clears.
// - Overtemperature longer than 160us turns output off, drops power-good.
// - Output re-enables once temperature falls below hysteresis release.
// - Overtemperature persisting, or recurring before a RUN cycle with it gone, after re-enable runs hiccup mode.
// - Command 10010 starts nonvolatile burn; done flag low until complete.
module cfp_fault_ctrl import cfp_pkg::*; #(
   parameter int RETRY_CYCLES = RETRY_CYCLES_DEF,
   parameter int START_CYCLES = START_CYCLES_DEF,
   parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic vin_uv,
   input wire logic ocp_in,
   input wire logic short_in,
   input wire logic otp_in,
   input wire logic enable_in,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic output_enable,
   output logic power_good_output,
   output logic nv_program_start,
   output logic irq
);
   localparam int TW = 24;

   typedef struct packed {
      cfp_faults_t s1;
      cfp_faults_t s2;
      logic en1;
      logic en2;
      cfp_state_t state;
      logic otp_seen;
      logic [7:0] nv_unlock_key;
      logic [4:0] program_command_field;
      logic program_done_flag;
      logic prog_busy;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic [7:0] rdata;
      logic oe;
      logic pg;
      logic prog_start;
   } cfp_state_reg_t;

   cfp_state_reg_t q;
   cfp_state_reg_t next_q;
   cfp_bus_t bus;
   logic por_n;
   logic ocp_hit;
   logic otp_hit;
   logic start_hit;
   logic retry_hit;
   logic prog_hit;
   logic start_run;
   logic retry_run;

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Undervoltage acts as power-on reset without filtering; the raw pin is
   // used so no synchroniser delay is added before everything is cleared
   assign por_n = rst_n & ~vin_uv;

   assign start_run = (q.state == CFP_START);
   assign retry_run = (q.state == CFP_HICCUP) || (q.state == CFP_THERMAL);

   cfp_timer #(.W(TW)) u_ocp (
      .sys_clk(sys_clk), .rst_n(por_n), .run(q.s2.over_current),
      .limit(TW'(OCP_CYCLES)), .hit(ocp_hit));
   cfp_timer #(.W(TW)) u_otp (
      .sys_clk(sys_clk), .rst_n(por_n), .run(q.s2.over_temp),
      .limit(TW'(OTP_CYCLES)), .hit(otp_hit));
   cfp_timer #(.W(TW)) u_start (
      .sys_clk(sys_clk), .rst_n(por_n), .run(start_run),
      .limit(TW'(START_CYCLES)), .hit(start_hit));
   cfp_timer #(.W(TW)) u_retry (
      .sys_clk(sys_clk), .rst_n(por_n), .run(retry_run),
      .limit(TW'(RETRY_CYCLES)), .hit(retry_hit));
   cfp_timer #(.W(TW)) u_prog (
      .sys_clk(sys_clk), .rst_n(por_n), .run(q.prog_busy),
      .limit(TW'(PROG_CYCLES)), .hit(prog_hit));

   always_comb begin
      logic [IRQ_W-1:0] ev;
      logic load_fault;
      logic [IRQ_W-1:0] clr;
      ev = '0;
      clr = '0;
      load_fault = 1'b0;
      next_q = q;
      next_q.s1 = '{under_volt: vin_uv, over_current: ocp_in, short_circuit: short_in, over_temp: otp_in};
      next_q.s2 = q.s1;
      next_q.en1 = enable_in;
      next_q.en2 = q.en1;
      next_q.prog_start = 1'b0;
      load_fault = ocp_hit || q.s2.short_circuit;

      case (q.state)
         CFP_OFF: begin
            if (q.en2) begin
               next_q.state = CFP_START;
            end
         end
         CFP_START: begin
            if (!q.en2) begin
               next_q.state = CFP_OFF;
            end else if (q.s2.short_circuit) begin
               next_q.state = CFP_HICCUP;
            end else if (ocp_hit) begin
               next_q.state = CFP_HICCUP;
            end else if (otp_hit) begin
               next_q.state = q.otp_seen ? CFP_HICCUP : CFP_THERMAL;
            end else if (start_hit) begin
               next_q.state = CFP_RUN;
            end
         end
         CFP_RUN: begin
            if (!q.en2) begin
               next_q.state = CFP_OFF;
            end else if (load_fault) begin
               next_q.state = CFP_HICCUP;
            end else if (otp_hit) begin
               next_q.state = q.otp_seen ? CFP_HICCUP : CFP_THERMAL;
            end
         end
         CFP_THERMAL: begin
            // Off until the sensor releases past its hysteresis
            if (!q.s2.over_temp) begin
               next_q.state = CFP_START;
               next_q.otp_seen = 1'b1;
            end
         end
         CFP_HICCUP: begin
            // A retry is a fresh startup; detection there re-enters hiccup
            if (retry_hit) begin
               next_q.state = CFP_START;
            end
         end
         default: begin
            next_q.state = CFP_OFF;
         end
      endcase

      // Remembered overtemperature ends after a clean run with the fault gone
      if (q.state == CFP_RUN && !q.s2.over_temp) begin
         next_q.otp_seen = 1'b0;
      end

      next_q.oe = (next_q.state == CFP_START) || (next_q.state == CFP_RUN);
      next_q.pg = (next_q.state == CFP_RUN);

      ev[IRQ_OTP] = otp_hit && !q.s2.over_temp ? 1'b0 : otp_hit && (q.state == CFP_RUN || q.state == CFP_START);
      ev[IRQ_OCP] = ocp_hit && (q.state == CFP_RUN || q.state == CFP_START);
      ev[IRQ_SHORT] = q.s2.short_circuit && (q.state == CFP_RUN || q.state == CFP_START);

      if (prog_hit) begin
         next_q.prog_busy = 1'b0;
         next_q.program_done_flag = 1'b1;
         ev[IRQ_PROG_DONE] = 1'b1;
      end

      next_q.rdata = '0;
      if (bus.rd) begin
         case (bus.addr)
            ADDR_UNLOCK: next_q.rdata = q.nv_unlock_key;
            ADDR_PROGRAM: next_q.rdata = {q.program_command_field, 1'b0, q.program_done_flag, 1'b0};
            ADDR_FAULTS: next_q.rdata = {5'h00, q.s2.short_circuit, q.s2.over_current, q.s2.over_temp};
            ADDR_IRQ_STATUS: next_q.rdata = {4'h0, q.irq_status};
            ADDR_IRQ_MASK: next_q.rdata = {4'h0, q.irq_mask};
            ADDR_CTRL_STATUS: next_q.rdata = {3'h0, q.pg, q.oe, q.state};
            default: next_q.rdata = 8'h00;
         endcase
      end

      if (bus.wr) begin
         case (bus.addr)
            ADDR_UNLOCK: next_q.nv_unlock_key = bus.wdata;
            ADDR_PROGRAM: begin
               next_q.program_command_field = bus.wdata[7:CMD_LSB];
               // Burn only while unlocked and idle; the key is consumed by it
               if (bus.wdata[7:CMD_LSB] == PROGRAM_CMD && q.nv_unlock_key == UNLOCK_KEY
                   && !q.prog_busy) begin
                  next_q.prog_busy = 1'b1;
                  next_q.program_done_flag = 1'b0;
                  next_q.prog_start = 1'b1;
                  next_q.nv_unlock_key = UNLOCK_RESET;
               end
            end
            ADDR_IRQ_STATUS: clr = bus.wdata[IRQ_W-1:0];
            ADDR_IRQ_MASK: next_q.irq_mask = bus.wdata[IRQ_W-1:0];
            default: begin
            end
         endcase
      end
      // Set wins over write-one-to-clear
      next_q.irq_status = (q.irq_status & ~clr) | ev;
   end

   always_ff @(posedge sys_clk) begin
      if (!por_n) begin
         q <= '0;
         q.state <= CFP_OFF;
         q.nv_unlock_key <= UNLOCK_RESET;
         q.program_command_field <= CMD_RESET;
         q.program_done_flag <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign reg_rdata = q.rdata;
   assign output_enable = q.oe;
   assign power_good_output = q.pg;
   assign nv_program_start = q.prog_start;
   assign irq = |(q.irq_status & q.irq_mask);
endmodule

// >>> cfp_fault_ctrl_assertions.sv
`timescale 1ns/1ns
module cfp_chk import cfp_pkg::*; #(
   parameter int RETRY_CYCLES = 50
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic vin_uv,
   input wire logic ocp_in,
   input wire logic short_in,
   input wire logic otp_in,
   input wire logic enable_in,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic output_enable,
   input wire logic power_good_output,
   input wire logic nv_program_start
);
   localparam int RLO = RETRY_CYCLES - 2;
   localparam int RHI = RETRY_CYCLES + 8;
   logic [15:0] ocp_run;
   logic [15:0] otp_run;
   // Raw runs lead the synchronised ones, so a legal trip always sees enough
   always_ff @(posedge sys_clk) begin
      ocp_run <= ocp_in ? ocp_run + 16'(ocp_run != 16'hFFFF) : 16'h0000;
      otp_run <= otp_in ? otp_run + 16'(otp_run != 16'hFFFF) : 16'h0000;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_quiet_drop;
      $fell(output_enable) && enable_in && !vin_uv && !$past(vin_uv) && !short_in && !$past(short_in, 4);
   endsequence
   chk_uv_off: assert property (vin_uv |=> !output_enable && !power_good_output)
      else $error("output alive after undervoltage");
   chk_short_fast: assert property ($rose(short_in) && output_enable |-> ##[1:5] !output_enable)
      else $error("short did not stop output");
   chk_short_hold: assert property ($fell(output_enable) && short_in |=> !output_enable [*8])
      else $error("output back too soon after short");
   chk_retry_gap: assert property ($fell(output_enable) && short_in |-> ##[RLO:RHI] output_enable)
      else $error("no retry after hiccup interval");
   chk_ocp_filter: assert property (s_quiet_drop ##0 (ocp_in && otp_run == 16'h0000) |-> ocp_run >= OCP_CYCLES)
      else $error("overload trip too early");
   chk_otp_filter: assert property (s_quiet_drop ##0 (otp_in && ocp_run == 16'h0000) |-> otp_run >= OTP_CYCLES)
      else $error("thermal trip too early");
   chk_pg_with_oe: assert property (power_good_output |-> output_enable)
      else $error("power good without output");
   chk_start_len: assert property ($rose(output_enable) |-> !power_good_output [*8])
      else $error("power good skipped startup");
   chk_burn_cmd: assert property (nv_program_start |-> $past(reg_wr) && $past(reg_addr) == ADDR_PROGRAM
      && ($past(reg_wdata) & 8'hF8) == {PROGRAM_CMD, 3'b000})
      else $error("burn without command");
endmodule
bind cfp_fault_ctrl cfp_chk #(.RETRY_CYCLES(RETRY_CYCLES)) u_cfp_chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .vin_uv(vin_uv), .ocp_in(ocp_in), .short_in(short_in), .otp_in(otp_in), .enable_in(enable_in),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .output_enable(output_enable),
   .power_good_output(power_good_output), .nv_program_start(nv_program_start));

// >>> cfp_stage_model.sv
`timescale 1ns/1ns
module cfp_stage_model (
   input wire logic sys_clk,
   input wire logic load_short,
   input wire logic load_over,
   input wire logic die_hot,
   output logic short_in,
   output logic ocp_in,
   output logic otp_in
);
   // Comparators hold a level for as long as the condition lasts
   initial {short_in, ocp_in, otp_in} = 3'b000;
   always @(posedge sys_clk) begin
      short_in <= load_short;
      ocp_in <= load_over;
      otp_in <= die_hot;
   end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top import cfp_pkg::*;;
   localparam int RT = 50;
   localparam int ST = 20;
   logic sys_clk = 1'b0, rst_n = 1'b0, vin_uv = 1'b0, enable_in = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic load_short = 1'b0, load_over = 1'b0, die_hot = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, d, k;
   logic ocp_in, short_in, otp_in, output_enable, power_good_output, nv_program_start, irq;
   int n_errors = 0, num_checks = 0;
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   cfp_stage_model u_cfp_stage_model (.sys_clk(sys_clk), .load_short(load_short), .load_over(load_over),
      .die_hot(die_hot), .short_in(short_in), .ocp_in(ocp_in), .otp_in(otp_in));
   cfp_fault_ctrl #(.RETRY_CYCLES(RT), .START_CYCLES(ST), .PROG_CYCLES(10)) u_cfp_fault_ctrl (
      .sys_clk(sys_clk), .rst_n(rst_n), .vin_uv(vin_uv), .ocp_in(ocp_in), .short_in(short_in),
      .otp_in(otp_in), .enable_in(enable_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .output_enable(output_enable),
      .power_good_output(power_good_output), .nv_program_start(nv_program_start), .irq(irq));
   function automatic logic [7:0] st_exp(logic [2:0] s);
      return {5'b00000, s};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Polls on the falling edge so settled outputs are seen
   task automatic wt(input logic [1:0] e, input int lim, input string m);
      for (int i = 0; i < lim && {power_good_output, output_enable} !== e; i++) begin
         @(negedge sys_clk);
      end
      chk({6'h00, power_good_output, output_enable}, {6'h00, e}, m);
   endtask
   initial begin
      void'($urandom(32'hB0744326));
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(ADDR_UNLOCK);
      chk(d, UNLOCK_RESET, "unlock reset");
      rd(8'h13);
      chk(d, 8'h00, "unmapped");
      k = 8'($urandom) | 8'h80;
      wr(ADDR_UNLOCK, k);
      rd(ADDR_UNLOCK);
      chk(d, k, "unlock rw");
      wr(ADDR_PROGRAM, 8'h90);
      #1 chk({7'h00, nv_program_start}, 8'h00, "burn locked");
      wr(ADDR_UNLOCK, UNLOCK_KEY);
      wr(ADDR_PROGRAM, 8'h90);
      #1 chk({7'h00, nv_program_start}, 8'h01, "burn start");
      rd(ADDR_PROGRAM);
      chk(d & 8'h02, 8'h00, "done low");
      repeat (15) @(posedge sys_clk);
      rd(ADDR_PROGRAM);
      chk(d & 8'h02, 8'h02, "done high");
      rd(ADDR_IRQ_STATUS);
      chk(d & 8'h08, 8'h08, "done event");
      chk({7'h00, irq}, 8'h00, "irq masked");
      wr(ADDR_IRQ_MASK, 8'h08);
      #1 chk({7'h00, irq}, 8'h01, "irq on");
      wr(ADDR_IRQ_STATUS, 8'h08);
      #1 chk({7'h00, irq}, 8'h00, "irq cleared");
      $display("test registers done");
      @(posedge sys_clk) enable_in <= 1'b1;
      wt(2'b01, 10, "start");
      wt(2'b11, ST + 10, "run");
      repeat ($urandom_range(9, 1)) @(posedge sys_clk);
      @(posedge sys_clk) load_short <= 1'b1;
      wt(2'b00, 6, "short off");
      rd(ADDR_CTRL_STATUS);
      chk(d, st_exp(CFP_HICCUP), "short hiccup");
      rd(ADDR_FAULTS);
      chk(d, 8'h04, "short fault bit");
      rd(ADDR_IRQ_STATUS);
      chk(d & 8'h04, 8'h04, "short event");
      wt(2'b01, RT + 10, "retry");
      @(posedge sys_clk) load_short <= 1'b0;
      wt(2'b11, RT + ST + 20, "short cleared");
      $display("test short done");
      @(posedge sys_clk) load_over <= 1'b1;
      repeat (OCP_CYCLES - 10) @(negedge sys_clk);
      chk({6'h00, power_good_output, output_enable}, 8'h03, "ocp early");
      wt(2'b00, 30, "ocp trip");
      @(posedge sys_clk) load_over <= 1'b0;
      wt(2'b11, RT + ST + 20, "ocp cleared");
      $display("test overload done");
      @(posedge sys_clk) die_hot <= 1'b1;
      repeat (OTP_CYCLES - 10) @(negedge sys_clk);
      chk({6'h00, power_good_output, output_enable}, 8'h03, "otp early");
      wt(2'b00, 30, "otp trip");
      @(posedge sys_clk) die_hot <= 1'b0;
      wt(2'b01, 20, "otp release");
      @(posedge sys_clk) die_hot <= 1'b1;
      wt(2'b00, OTP_CYCLES + 40, "otp again");
      rd(ADDR_CTRL_STATUS);
      chk(d, st_exp(CFP_HICCUP), "otp hiccup");
      @(posedge sys_clk) die_hot <= 1'b0;
      wt(2'b11, RT + ST + 20, "otp cleared");
      $display("test thermal done");
      @(posedge sys_clk) vin_uv <= 1'b1;
      @(posedge sys_clk) vin_uv <= 1'b0;
      #1 chk({6'h00, power_good_output, output_enable}, 8'h00, "uv off");
      rd(ADDR_IRQ_STATUS);
      chk(d, 8'h00, "uv clears status");
      $display("test undervoltage done");
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      end_sim();
   end
endmodule
